// *** hdl/cspc_pkg.sv ***
// Purpose: Shared constants for the CPU sleep/idle power controller
// Assumes: Single 100 MHz core clock
// Notes:   Clock source codes and timing figures live here
package cspc_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned OSC_START_US     = 1000;
  localparam int unsigned OSC_START_CYC    = OSC_START_US * CLK_MHZ;
  localparam int unsigned PLL_LOCK_US      = 100;
  localparam int unsigned PLL_LOCK_CYC     = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned PRIO_W           = 3;
  localparam int unsigned DIV_W            = 2;
  localparam int unsigned SRC_W            = 3;
  localparam logic [2:0]  SRC_FRC          = 3'h0;
  localparam logic [2:0]  SRC_FRC_DIV      = 3'h1;
  localparam logic [2:0]  SRC_LOW_POWER_INTERNAL_RC_OSC         = 3'h2;
  localparam logic [2:0]  SRC_SOSC         = 3'h3;
  localparam logic [2:0]  SRC_POSC         = 3'h4;
  localparam logic [2:0]  SRC_POSC_PLL     = 3'h5;
  localparam logic [2:0]  SRC_FRC_PLL      = 3'h6;
  localparam logic [2:0]  DIV_MAX_CNT      = 3'h7;
  typedef enum logic [1:0] {
    CSPC_RUN   = 2'b00,
    CSPC_IDLE  = 2'b01,
    CSPC_SLEEP = 2'b10,
    CSPC_START = 2'b11
  } cspc_state_t;
endpackage

// *** hdl/cspc_pb_divider.sv ***
// Purpose: Peripheral clock enable divider feeding read completion
// Assumes: Divisor code 0..3 selects ratio 1, 2, 4, 8
// Notes:   Enable pulse stands in for the peripheral bus clock edge
`timescale 1ns/10ps
module cspc_pb_divider (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [1:0] peripheral_clock_divisor,
  output logic            pb_tick
);
  logic [2:0] cnt;
  logic [2:0] limit;
  assign limit = 3'((4'h1 << peripheral_clock_divisor) - 4'h1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt     <= 3'h0;
      pb_tick <= 1'b0;
    end else if (!run) begin
      cnt     <= 3'h0;
      pb_tick <= 1'b0;
    end else begin
      cnt     <= (cnt >= limit) ? 3'h0 : cnt + 3'h1;
      pb_tick <= (cnt >= limit);
    end
  end

  chk_tick_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
    (pb_tick && run && $stable(peripheral_clock_divisor) && peripheral_clock_divisor == 2'h3)
      |=> !pb_tick [*7])
    else $error("Peripheral tick spacing wrong at ratio eight");
endmodule

// *** hdl/cspc_core.sv ***
// Purpose: Top of the CPU sleep/idle power controller
// Assumes: Wait, interrupt and reset inputs come from same-clock logic
// Notes:   Delay counts are parameters so simulation can shorten them
// Operation
// - Wait with sleep bit clear enters Idle
// - Sleep halts CPU and system clock source
// - Clock failure monitor off during Sleep
// - Sleep entry never clears watchdog counter
// - External and low-power clocked peripherals run
// - Output pins keep drive in Sleep
// - USB request keeps oscillator alive in Sleep
// - Higher priority enabled interrupt wakes from Sleep
// - Low priority Sleep wake enters Idle instead
// - Idle halts CPU clock, keeps system clock
// - Idle stops peripherals with idle-stop bit
// - Higher priority interrupt exits Idle only
// - Reset or watchdog time-out exits low power
// - Start-up delay on crystal/PLL source selected in Run or on wake from Sleep to Run
// - Run clock from internal RC, secondary, primary or PLL
// - Peripherals clocked from system clock fraction
// - Divisor selects ratio one, two, four, eight
// - Peripheral reads finish on next peripheral tick
`timescale 1ns/10ps
module cspc_core #(
  parameter int unsigned NUM_PERIPH    = 8,
  parameter int unsigned OSC_START_CYC = cspc_pkg::OSC_START_CYC,
  parameter int unsigned PLL_LOCK_CYC  = cspc_pkg::PLL_LOCK_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wait_exec,
  input  wire logic                  sleep_select_bit,
  input  wire logic                  irq_pending,
  input  wire logic [2:0]            irq_priority,
  input  wire logic [2:0]            cpu_priority,
  input  wire logic                  soft_reset_req,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  usb_osc_req,
  input  wire logic [2:0]            clk_source_sel,
  input  wire logic [1:0]            peripheral_clock_divisor,
  input  wire logic [NUM_PERIPH-1:0] idle_stop_bit,
  input  wire logic                  pb_read_req,
  output logic                       cpu_clk_en,
  output logic                       main_system_clock_src_en,
  output logic                       pb_clk_en,
  output logic [NUM_PERIPH-1:0]      periph_clk_en,
  output logic                       async_periph_en,
  output logic                       clock_failure_monitor_en,
  output logic                       watchdog_clear,
  output logic                       pin_drive_hold,
  output logic                       pb_read_done,
  output logic [2:0]                 run_clk_source,
  output logic                       in_idle,
  output logic                       in_sleep,
  output logic                       osc_starting
);
  localparam int unsigned DLY_W = $clog2(OSC_START_CYC + PLL_LOCK_CYC + 1);

  initial begin
    if (NUM_PERIPH < 1 || OSC_START_CYC < 1 || PLL_LOCK_CYC < 1)
      $error("cspc_core: parameters out of range");
  end

  cspc_pkg::cspc_state_t state;
  cspc_pkg::cspc_state_t next_state;
  logic [DLY_W-1:0]      dly;
  logic [DLY_W-1:0]      next_dly;
  logic [2:0]            active_src;
  logic                  read_pending;
  logic                  pb_tick;

  wire wake_any     = soft_reset_req || watchdog_timeout;
  wire irq_high     = irq_pending && (irq_priority > cpu_priority);
  wire irq_low      = irq_pending && !irq_high;
  wire src_xtal     = (clk_source_sel == cspc_pkg::SRC_POSC);
  wire src_pll      = (clk_source_sel == cspc_pkg::SRC_POSC_PLL) ||
                      (clk_source_sel == cspc_pkg::SRC_FRC_PLL);
  wire src_changed  = (clk_source_sel != active_src);
  wire need_delay   = src_changed && (src_xtal || src_pll);
  wire [DLY_W-1:0] start_cnt = src_pll ? DLY_W'(OSC_START_CYC + PLL_LOCK_CYC)
                                       : DLY_W'(OSC_START_CYC);
  wire sleeping     = (state == cspc_pkg::CSPC_SLEEP);
  wire idling       = (state == cspc_pkg::CSPC_IDLE);
  wire running      = (state == cspc_pkg::CSPC_RUN);

  always_comb begin
    next_state = state;
    next_dly   = dly;
    case (state)
      cspc_pkg::CSPC_RUN: begin
        if (need_delay) begin
          next_state = cspc_pkg::CSPC_START;
          next_dly   = start_cnt;
        end else if (wait_exec && sleep_select_bit) begin
          next_state = cspc_pkg::CSPC_SLEEP;
        end else if (wait_exec) begin
          next_state = cspc_pkg::CSPC_IDLE;
        end
      end
      cspc_pkg::CSPC_IDLE: begin
        if (irq_high || wake_any) begin
          next_state = cspc_pkg::CSPC_RUN;
        end
      end
      cspc_pkg::CSPC_SLEEP: begin
        if (irq_high || wake_any) begin
          // Waking may need the source restarted
          next_state = (src_xtal || src_pll) ? cspc_pkg::CSPC_START
                                             : cspc_pkg::CSPC_RUN;
          next_dly   = start_cnt;
        end else if (irq_low) begin
          next_state = cspc_pkg::CSPC_IDLE;
        end
      end
      cspc_pkg::CSPC_START: begin
        if (dly <= DLY_W'(1)) begin
          next_state = cspc_pkg::CSPC_RUN;
          next_dly   = '0;
        end else begin
          next_dly   = dly - DLY_W'(1);
        end
      end
      default: begin
        next_state = cspc_pkg::CSPC_RUN;
        next_dly   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= cspc_pkg::CSPC_RUN;
      dly   <= '0;
    end else begin
      state <= next_state;
      dly   <= next_dly;
    end
  end

  // Active source follows selection once any start-up wait is done
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_src <= cspc_pkg::SRC_FRC;
    end else if (next_state == cspc_pkg::CSPC_RUN && state != cspc_pkg::CSPC_SLEEP) begin
      active_src <= clk_source_sel;
    end
  end

  cspc_pb_divider u_pb_div (
    .core_clk                 (core_clk),
    .sys_rst                  (sys_rst),
    .run                      (!sleeping),
    .peripheral_clock_divisor (peripheral_clock_divisor),
    .pb_tick                  (pb_tick)
  );

  // Reads wait for the next peripheral tick
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_pending <= 1'b0;
      pb_read_done <= 1'b0;
    end else begin
      pb_read_done <= (read_pending || pb_read_req) && pb_tick;
      if (pb_tick) begin
        read_pending <= 1'b0;
      end else if (pb_read_req) begin
        read_pending <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_clk_en               <= 1'b1;
      main_system_clock_src_en            <= 1'b1;
      pb_clk_en                <= 1'b0;
      periph_clk_en            <= '0;
      async_periph_en          <= 1'b1;
      clock_failure_monitor_en <= 1'b1;
      watchdog_clear           <= 1'b0;
      pin_drive_hold           <= 1'b1;
      run_clk_source           <= cspc_pkg::SRC_FRC;
      in_idle                  <= 1'b0;
      in_sleep                 <= 1'b0;
      osc_starting             <= 1'b0;
    end else begin
      cpu_clk_en               <= (next_state == cspc_pkg::CSPC_RUN);
      main_system_clock_src_en            <= (next_state != cspc_pkg::CSPC_SLEEP) || usb_osc_req;
      pb_clk_en                <= (next_state != cspc_pkg::CSPC_SLEEP) && pb_tick;
      for (int i = 0; i < NUM_PERIPH; i++) begin
        periph_clk_en[i] <= pb_tick && (next_state != cspc_pkg::CSPC_SLEEP) &&
                            !((next_state == cspc_pkg::CSPC_IDLE) && idle_stop_bit[i]);
      end
      async_periph_en          <= 1'b1;
      clock_failure_monitor_en <= (next_state != cspc_pkg::CSPC_SLEEP);
      watchdog_clear           <= 1'b0;
      pin_drive_hold           <= 1'b1;
      run_clk_source           <= (next_state == cspc_pkg::CSPC_RUN) ? clk_source_sel
                                                                     : active_src;
      in_idle                  <= (next_state == cspc_pkg::CSPC_IDLE);
      in_sleep                 <= (next_state == cspc_pkg::CSPC_SLEEP);
      osc_starting             <= (next_state == cspc_pkg::CSPC_START);
    end
  end

  sequence s_wait_sleep;
    running && wait_exec && sleep_select_bit && !need_delay;
  endsequence

  chk_sleep_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_wait_sleep |=> in_sleep && !cpu_clk_en)
    else $error("Sleep not entered on wait with sleep bit");
  chk_idle_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
    running && wait_exec && !sleep_select_bit && !need_delay |=> in_idle && main_system_clock_src_en)
    else $error("Idle not entered on wait");
  chk_sleep_osc: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_sleep && !usb_osc_req && $past(!usb_osc_req) |-> !main_system_clock_src_en)
    else $error("System clock source running in sleep");
  chk_clock_failure_monitor_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_sleep |-> !clock_failure_monitor_en)
    else $error("Clock monitor active in sleep");
  chk_wdt_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(in_sleep) |-> !watchdog_clear)
    else $error("Watchdog cleared on sleep entry");
  chk_usb_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    sleeping && usb_osc_req |=> main_system_clock_src_en)
    else $error("USB request did not hold oscillator");
  chk_low_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    sleeping && irq_low && !wake_any |=> in_idle && !cpu_clk_en)
    else $error("Low priority sleep wake not to idle");
  chk_idle_stay: assert property (@(posedge core_clk) disable iff (sys_rst)
    idling && !irq_high && !wake_any |=> in_idle)
    else $error("Idle left without cause");
  chk_idle_exit: assert property (@(posedge core_clk) disable iff (sys_rst)
    idling && (irq_high || wake_any) |=> cpu_clk_en)
    else $error("Idle not left on wake event");
  chk_idle_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_idle && idle_stop_bit[0] && $past(idle_stop_bit[0]) |-> !periph_clk_en[0])
    else $error("Idle-stop peripheral still clocked");
  chk_start_dly: assert property (@(posedge core_clk) disable iff (sys_rst)
    running && need_delay |=> osc_starting && !cpu_clk_en)
    else $error("Start-up delay skipped");
  chk_read_done: assert property (@(posedge core_clk) disable iff (sys_rst)
    pb_read_done |-> $past(pb_tick))
    else $error("Read done off peripheral tick");

  // Wake steps built as sequences so the source check reuses the trigger
  sequence s_sleep_wake;
    sleeping && (irq_high || wake_any);
  endsequence

  sequence s_read_hit;
    (pb_read_req || read_pending) && pb_tick;
  endsequence

  chk_sleep_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_sleep_wake |=> !in_sleep && !in_idle)
    else $error("Sleep not left on wake event");

  chk_fast_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_sleep_wake ##0 (!src_xtal && !src_pll) |=> cpu_clk_en)
    else $error("Wake without start-up did not run the CPU");

  chk_read_hit: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_read_hit |=> pb_read_done)
    else $error("Read not finished on peripheral tick");

  chk_sleep_cpu: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_sleep |-> !cpu_clk_en && !pb_clk_en)
    else $error("CPU or peripheral clock running in sleep");

  chk_clock_failure_monitor_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    !in_sleep |-> clock_failure_monitor_en)
    else $error("Clock monitor off outside sleep");

  chk_wdt_never: assert property (@(posedge core_clk) disable iff (sys_rst)
    !watchdog_clear)
    else $error("Watchdog clear raised");

  chk_async_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    async_periph_en)
    else $error("Own-clock peripherals stopped");

  chk_pin_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    pin_drive_hold)
    else $error("Pin drive released");

  chk_idle_clk: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_idle |-> !cpu_clk_en && main_system_clock_src_en)
    else $error("Idle clocks wrong");

  chk_idle_run: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_idle && !$past(idle_stop_bit[0]) && $past(pb_tick) |-> periph_clk_en[0])
    else $error("Running peripheral stopped in idle");

  chk_run_source: assert property (@(posedge core_clk) disable iff (sys_rst)
    running && !need_delay && !wait_exec |=> run_clk_source == $past(clk_source_sel))
    else $error("Run clock source not followed");

  chk_pb_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
    pb_clk_en |-> $past(pb_tick))
    else $error("Peripheral clock off tick");

  // Guard on reset so the cleared tick register is not mistaken for a miss
  chk_tick_ratio1: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(sleeping) && $past(peripheral_clock_divisor) == 2'h0
      |-> pb_tick)
    else $error("Peripheral tick missing at ratio one");
endmodule

// *** verification/cspc_irq_model.sv ***
// Purpose: Interrupt controller stand-in facing the power controller
// Assumes: A request stays pending until the CPU clock runs again
// Notes:   Priority lines show junk while nothing is pending
`timescale 1ns/10ps
module cspc_irq_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       raise,
  input  wire logic [2:0] raise_prio,
  input  wire logic       cpu_clk_en,
  output logic            irq_pending,
  output logic [2:0]      irq_priority
);
  logic [2:0] last_prio;
  // Halted CPU cannot acknowledge, so the request waits for its clock
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_pending <= 1'b0;
      last_prio   <= 3'h0;
    end else if (raise) begin
      irq_pending <= 1'b1;
      last_prio   <= raise_prio;
    end else if (cpu_clk_en) begin
      irq_pending <= 1'b0;
    end
  end
  // Inverted value so a released line is never read as still valid
  assign irq_priority = irq_pending ? last_prio : ~last_prio;
endmodule

// *** verification/cspc_core_bench.sv ***
// Purpose: Self-checking bench for the CPU sleep/idle power controller
// Assumes: Inputs change and outputs are read on the falling edge
// Notes:   Start-up counts shortened to 4 and 2 cycles
`timescale 1ns/10ps
module cspc_core_bench;
  localparam int OSC_N = 4;
  localparam int PLL_N = 2;
  logic       core_clk, sys_rst, wait_exec, sleep_select_bit, soft_reset_req, raise;
  logic       watchdog_timeout, usb_osc_req, pb_read_req, irq_pending, cpu_clk_en;
  logic       main_system_clock_src_en, pb_clk_en, async_periph_en, clock_failure_monitor_en;
  logic       watchdog_clear, pin_drive_hold, pb_read_done, in_idle, in_sleep, osc_starting;
  logic [2:0] irq_priority, cpu_priority, clk_source_sel, run_clk_source, raise_prio;
  logic [1:0] peripheral_clock_divisor;
  logic [7:0] idle_stop_bit, periph_clk_en, stop_or, run_or;
  int         n_errors = 0;
  int         n_checks = 0;
  int         pb_cnt, st_cnt, c, e;

  cspc_core #(.NUM_PERIPH(8), .OSC_START_CYC(OSC_N), .PLL_LOCK_CYC(PLL_N)) cspc_core_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .wait_exec(wait_exec),
    .sleep_select_bit(sleep_select_bit), .irq_pending(irq_pending),
    .irq_priority(irq_priority), .cpu_priority(cpu_priority),
    .soft_reset_req(soft_reset_req), .watchdog_timeout(watchdog_timeout),
    .usb_osc_req(usb_osc_req), .clk_source_sel(clk_source_sel),
    .peripheral_clock_divisor(peripheral_clock_divisor), .idle_stop_bit(idle_stop_bit),
    .pb_read_req(pb_read_req), .cpu_clk_en(cpu_clk_en), .main_system_clock_src_en(main_system_clock_src_en),
    .pb_clk_en(pb_clk_en), .periph_clk_en(periph_clk_en),
    .async_periph_en(async_periph_en), .clock_failure_monitor_en(clock_failure_monitor_en),
    .watchdog_clear(watchdog_clear), .pin_drive_hold(pin_drive_hold),
    .pb_read_done(pb_read_done), .run_clk_source(run_clk_source), .in_idle(in_idle),
    .in_sleep(in_sleep), .osc_starting(osc_starting));

  cspc_irq_model cspc_irq_model_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .raise(raise), .raise_prio(raise_prio),
    .cpu_clk_en(cpu_clk_en), .irq_pending(irq_pending), .irq_priority(irq_priority));

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk_vec(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic kick(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic irq(input logic [2:0] p);
    raise_prio = p;
    kick(raise);
  endtask
  task automatic observe(input int n);
    pb_cnt = 0;
    st_cnt = 0;
    stop_or = 8'h00;
    run_or = 8'h00;
    repeat (n) begin
      step(1);
      pb_cnt += pb_clk_en;
      st_cnt += osc_starting;
      stop_or |= periph_clk_en & idle_stop_bit;
      run_or |= periph_clk_en & ~idle_stop_bit;
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #50000;
    n_errors++;
    $display("MISMATCH run length expected finish seen timeout");
    summarize();
  end

  initial begin
    {wait_exec, sleep_select_bit, soft_reset_req, watchdog_timeout} = 4'h0;
    {usb_osc_req, pb_read_req, raise} = 3'h0;
    raise_prio = 3'h0;
    cpu_priority = 3'h3;
    clk_source_sel = 3'h0;
    peripheral_clock_divisor = 2'h0;
    idle_stop_bit = 8'ha5;
    sys_rst = 1'b1;
    step(4);
    chk_bit("clock_failure_monitor reset", 1'b1, clock_failure_monitor_en);
    chk_bit("pin hold reset", 1'b1, pin_drive_hold);
    sys_rst = 1'b0;
    for (int s = 0; s < 7; s++) begin
      clk_source_sel = s[2:0];
      observe(12);
      e = (s > 3) ? OSC_N + ((s > 4) ? PLL_N : 0) : 0;
      chk_bit("start length", 1'b1, st_cnt >= e && st_cnt <= e + (e > 0));
      chk_vec("run_clk_source", {5'h00, s[2:0]}, {5'h00, run_clk_source});
    end
    kick(wait_exec);
    step(2);
    chk_bit("in_idle", 1'b1, in_idle);
    chk_bit("cpu_clk_en", 1'b0, cpu_clk_en);
    chk_bit("main_system_clock_src_en", 1'b1, main_system_clock_src_en);
    observe(8);
    chk_vec("stopped periph", 8'h00, stop_or);
    chk_vec("running periph", 8'h5a, run_or);
    irq(3'h3);
    step(3);
    chk_bit("in_idle", 1'b1, in_idle);
    irq(3'h4);
    observe(4);
    chk_bit("cpu_clk_en", 1'b1, cpu_clk_en);
    chk_bit("no start on idle exit", 1'b1, st_cnt == 0);
    clk_source_sel = 3'h0;
    step(4);
    sleep_select_bit = 1'b1;
    kick(wait_exec);
    step(2);
    chk_bit("in_sleep", 1'b1, in_sleep);
    chk_bit("cpu_clk_en", 1'b0, cpu_clk_en);
    chk_bit("main_system_clock_src_en", 1'b0, main_system_clock_src_en);
    chk_bit("clock_failure_monitor", 1'b0, clock_failure_monitor_en);
    chk_bit("watchdog_clear", 1'b0, watchdog_clear);
    chk_bit("async_periph_en", 1'b1, async_periph_en);
    chk_bit("pin_drive_hold", 1'b1, pin_drive_hold);
    observe(8);
    chk_bit("pb silent", 1'b1, pb_cnt == 0);
    irq(3'h2);
    step(3);
    chk_bit("in_idle", 1'b1, in_idle);
    chk_bit("in_sleep", 1'b0, in_sleep);
    observe(8);
    chk_bit("pb running", 1'b1, pb_cnt == 8);
    chk_bit("cpu_clk_en", 1'b0, cpu_clk_en);
    kick(watchdog_timeout);
    step(2);
    chk_bit("cpu_clk_en", 1'b1, cpu_clk_en);
    usb_osc_req = 1'b1;
    kick(wait_exec);
    step(2);
    chk_bit("main_system_clock_src_en", 1'b1, main_system_clock_src_en);
    irq(3'h7);
    step(3);
    chk_bit("in_sleep", 1'b0, in_sleep);
    chk_bit("cpu_clk_en", 1'b1, cpu_clk_en);
    usb_osc_req = 1'b0;
    kick(wait_exec);
    step(2);
    kick(soft_reset_req);
    step(3);
    chk_bit("in_sleep", 1'b0, in_sleep);
    for (int d = 0; d < 4; d++) begin
      peripheral_clock_divisor = d[1:0];
      observe(16);
      chk_bit("pb ticks", 1'b1, pb_cnt == (16 >> d));
      kick(pb_read_req);
      c = 1;
      while (pb_read_done !== 1'b1 && c < 20) begin
        step(1);
        c++;
      end
      chk_bit("read latency", 1'b1, c <= (1 << d) + 2);
    end
    summarize();
  end
endmodule
